/* pkg/adbo_pkg.sv */
// constants and types shared by the add and bit operations datapath
package adbo_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ACC    = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_CTRL   = 5'h0C;
  localparam logic [4:0] REG_FADDR  = 5'h10;
  localparam logic [4:0] REG_FDATA  = 5'h14;

  // command word field positions
  localparam int CMD_LIT_LSB  = 0;
  localparam int CMD_FILE_LSB = 8;
  localparam int CMD_DEST_BIT = 15;
  localparam int CMD_BIT_LSB  = 16;
  localparam int CMD_OP_LSB   = 20;

  // status word field positions
  localparam int STAT_CARRY = 0;
  localparam int STAT_HC    = 1;
  localparam int STAT_ZERO  = 2;
  localparam int STAT_SKIP  = 3;

  // control word field positions
  localparam int CTRL_PSA = 0;

  // reset values
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] FILE_RST  = 8'h00;
  localparam logic       FLAG_RST  = 1'h0;
  localparam logic       PSA_RST   = 1'h0;
  localparam logic [6:0] FADDR_RST = 7'h00;

  // operation codes carried in the command word
  typedef enum logic [2:0] {
    OP_ADD_LITERAL_TO_ACC   = 3'h0,
    OP_ADD_ACC_AND_FILE     = 3'h1,
    OP_AND_LITERAL_WITH_ACC = 3'h2,
    OP_AND_ACC_WITH_FILE    = 3'h3,
    OP_BIT_CLEAR_FILE       = 3'h4,
    OP_BIT_SET_FILE         = 3'h5,
    OP_TEST_BIT_SKIP_ZERO   = 3'h6,
    OP_TEST_BIT_SKIP_ONE    = 3'h7
  } adbo_op_t;

endpackage : adbo_pkg

/* hdl/adbo_datapath.sv */
// add, and, bit clear/set and bit test datapath behind an avalon-mm slave
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - add literal: accumulator plus 8-bit literal into accumulator, carry, half carry, zero
// - add file: accumulator plus addressed file register, updates carry, half carry, zero
// - destination bit 0 sends result to accumulator, 1 back to the file register
// - and literal: accumulator and literal into accumulator, only zero flag updated
// - and file: accumulator and file register to chosen destination, only zero flag
// - bit clear forces bit b of the file register low, flags untouched
// - bit set forces bit b of the file register high, flags untouched
// - skip if zero: bit low discards next command as a no-operation, two cycles
// - skip if one: bit high discards next command as a no-operation, two cycles
// - bit tests only read the register bit and leave every flag but skip alone
// - read-modify-write of the port register takes the pin values as operand
// - a command writing the timer zero counter clears its prescaler when assigned to it, a plain file data write does not
module adbo_datapath
  import adbo_pkg::*;
#(
  parameter int         FILE_DEPTH      = 128,
  parameter logic [6:0] PORT_ADDR       = 7'h05,
  parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01
)(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [7:0]  PORT_PINS,
  output logic      [7:0]  PORT_LATCH,
  output logic             PRESCALER_CLR
);

  //////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (FILE_DEPTH != 128)
  begin : g_depth_chk
    $error("file depth must match the 7-bit file address");
  end
  if (PORT_ADDR == TIMER_ZERO_ADDR)
  begin : g_addr_chk
    $error("port and timer zero registers need distinct addresses");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [FILE_DEPTH-1:0][7:0] file;
    logic [7:0]                 acc;
    logic                       carry;
    logic                       half_carry;
    logic                       zero;
    logic                       skip;
    logic                       psa;
    logic [6:0]                 faddr;
    logic [7:0]                 pin_s1;
    logic [7:0]                 pin_s2;
    logic                       ack;
    logic [31:0]                rdata;
    logic                       presc_clr;
  } adbo_state_t;

  adbo_state_t st_ff;
  adbo_state_t nxt_st;

  // file operand: the port register reads its synchronised pins
  function automatic logic [7:0] file_operand(input adbo_state_t s, input logic [6:0] a);
    if (a == PORT_ADDR)
    begin
      file_operand = s.pin_s2;
    end
    else
    begin
      file_operand = s.file[a];
    end
  endfunction : file_operand

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  adbo_op_t    cmd_op;
  logic [7:0]  cmd_lit;
  logic [6:0]  cmd_file;
  logic        cmd_dest;
  logic [2:0]  cmd_bit;
  logic [7:0]  operand;
  logic        test_bit;
  logic        wr_ack;
  logic        exec;
  logic        drop;
  logic [8:0]  sum;
  logic [4:0]  low_sum;
  logic [7:0]  result;
  logic        wr_file;
  logic [7:0]  wr_val;

  // command fields and bus qualifiers
  assign cmd_op   = adbo_op_t'(AVS_WRITEDATA[CMD_OP_LSB +: 3]);
  assign cmd_lit  = AVS_WRITEDATA[CMD_LIT_LSB +: 8];
  assign cmd_file = AVS_WRITEDATA[CMD_FILE_LSB +: 7];
  assign cmd_dest = AVS_WRITEDATA[CMD_DEST_BIT];
  assign cmd_bit  = AVS_WRITEDATA[CMD_BIT_LSB +: 3];
  assign operand  = file_operand(st_ff, cmd_file);
  assign test_bit = operand[cmd_bit];
  assign wr_ack   = AVS_WRITE & st_ff.ack;
  assign exec     = wr_ack && (AVS_ADDRESS == REG_CMD) && !st_ff.skip;
  assign drop     = wr_ack && (AVS_ADDRESS == REG_CMD) && st_ff.skip;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.pin_s1    = PORT_PINS;
    nxt_st.pin_s2    = st_ff.pin_s1;
    nxt_st.ack       = (AVS_READ | AVS_WRITE) & ~st_ff.ack;
    nxt_st.presc_clr = 1'b0;
    sum              = 9'h000;
    low_sum          = 5'h00;
    result           = 8'h00;
    wr_file          = 1'b0;
    wr_val           = 8'h00;

    // register read, data stands at the acknowledge edge
    if (AVS_READ && !st_ff.ack)
    begin
      unique case (AVS_ADDRESS)
        REG_ACC:    nxt_st.rdata = {24'h000000, st_ff.acc};
        REG_STATUS: nxt_st.rdata = {28'h0000000, st_ff.skip, st_ff.zero,
                                    st_ff.half_carry, st_ff.carry};
        REG_CTRL:   nxt_st.rdata = {31'h00000000, st_ff.psa};
        REG_FADDR:  nxt_st.rdata = {25'h0000000, st_ff.faddr};
        REG_FDATA:  nxt_st.rdata = {24'h000000, file_operand(st_ff, st_ff.faddr)};
        default:    nxt_st.rdata = 32'h00000000;
      endcase
    end

    // plain register writes
    if (wr_ack)
    begin
      unique case (AVS_ADDRESS)
        REG_ACC:    nxt_st.acc = AVS_WRITEDATA[7:0];
        REG_STATUS:
        begin
          nxt_st.carry      = AVS_WRITEDATA[STAT_CARRY];
          nxt_st.half_carry = AVS_WRITEDATA[STAT_HC];
          nxt_st.zero       = AVS_WRITEDATA[STAT_ZERO];
        end
        REG_CTRL:   nxt_st.psa = AVS_WRITEDATA[CTRL_PSA];
        REG_FADDR:  nxt_st.faddr = AVS_WRITEDATA[6:0];
        REG_FDATA:  nxt_st.file[st_ff.faddr] = AVS_WRITEDATA[7:0];
        default:    nxt_st.skip = st_ff.skip;
      endcase
    end

    // discarded command runs as a no-operation
    if (drop)
    begin
      nxt_st.skip = 1'b0;
    end

    // command execution
    if (exec)
    begin
      unique case (cmd_op)
        OP_ADD_LITERAL_TO_ACC, OP_ADD_ACC_AND_FILE:
        begin
          if (cmd_op == OP_ADD_LITERAL_TO_ACC)
          begin
            sum     = {1'b0, st_ff.acc} + {1'b0, cmd_lit};
            low_sum = {1'b0, st_ff.acc[3:0]} + {1'b0, cmd_lit[3:0]};
          end
          else
          begin
            sum     = {1'b0, st_ff.acc} + {1'b0, operand};
            low_sum = {1'b0, st_ff.acc[3:0]} + {1'b0, operand[3:0]};
          end
          result            = sum[7:0];
          nxt_st.carry      = sum[8];
          nxt_st.half_carry = low_sum[4];
          nxt_st.zero       = (result == 8'h00);
        end
        OP_AND_LITERAL_WITH_ACC:
        begin
          result      = st_ff.acc & cmd_lit;
          nxt_st.zero = (result == 8'h00);
        end
        OP_AND_ACC_WITH_FILE:
        begin
          result      = st_ff.acc & operand;
          nxt_st.zero = (result == 8'h00);
        end
        OP_BIT_CLEAR_FILE:
        begin
          wr_file = 1'b1;
          wr_val  = operand & ~(8'h01 << cmd_bit);
        end
        OP_BIT_SET_FILE:
        begin
          wr_file = 1'b1;
          wr_val  = operand | (8'h01 << cmd_bit);
        end
        OP_TEST_BIT_SKIP_ZERO: nxt_st.skip = ~test_bit;
        OP_TEST_BIT_SKIP_ONE:  nxt_st.skip = test_bit;
      endcase

      // destination select for the two-operand operations
      if (cmd_op inside {OP_ADD_LITERAL_TO_ACC, OP_AND_LITERAL_WITH_ACC})
      begin
        nxt_st.acc = result;
      end
      else if (cmd_op inside {OP_ADD_ACC_AND_FILE, OP_AND_ACC_WITH_FILE})
      begin
        if (cmd_dest)
        begin
          wr_file = 1'b1;
          wr_val  = result;
        end
        else
        begin
          nxt_st.acc = result;
        end
      end
    end

    // file write, timer zero write also clears its prescaler when assigned to it
    if (wr_file)
    begin
      nxt_st.file[cmd_file] = wr_val;
      nxt_st.presc_clr      = (cmd_file == TIMER_ZERO_ADDR) && st_ff.psa;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_ff            <= '0;
      st_ff.file       <= {FILE_DEPTH{FILE_RST}};
      st_ff.acc        <= ACC_RST;
      st_ff.carry      <= FLAG_RST;
      st_ff.half_carry <= FLAG_RST;
      st_ff.zero       <= FLAG_RST;
      st_ff.skip       <= FLAG_RST;
      st_ff.psa        <= PSA_RST;
      st_ff.faddr      <= FADDR_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // one wait state on every access
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_ff.ack;
  assign AVS_READDATA    = st_ff.rdata;
  assign PORT_LATCH      = st_ff.file[PORT_ADDR];
  assign PRESCALER_CLR   = st_ff.presc_clr;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  add_lit_sum_a: assert property (
    exec && cmd_op == OP_ADD_LITERAL_TO_ACC
    |=> st_ff.acc == 8'($past(st_ff.acc) + $past(cmd_lit)))
    else $error("add literal result wrong");

  add_file_dest_a: assert property (
    exec && cmd_op == OP_ADD_ACC_AND_FILE && cmd_dest && cmd_file != PORT_ADDR
    |=> st_ff.file[$past(cmd_file)] == 8'($past(st_ff.acc) + $past(operand))
        && st_ff.acc == $past(st_ff.acc))
    else $error("add file to file destination wrong");

  dest_acc_a: assert property (
    exec && cmd_op == OP_AND_ACC_WITH_FILE && !cmd_dest
    |=> st_ff.acc == ($past(st_ff.acc) & $past(operand))
        && $stable(st_ff.file))
    else $error("destination zero did not reach accumulator");

  and_lit_flags_a: assert property (
    exec && cmd_op == OP_AND_LITERAL_WITH_ACC
    |=> st_ff.acc == ($past(st_ff.acc) & $past(cmd_lit))
        && $stable(st_ff.carry) && $stable(st_ff.half_carry))
    else $error("and literal touched carry flags or result wrong");

  and_file_dest_a: assert property (
    exec && cmd_op == OP_AND_ACC_WITH_FILE && cmd_dest && cmd_file != PORT_ADDR
    |=> st_ff.file[$past(cmd_file)] == ($past(st_ff.acc) & $past(operand))
        && $stable(st_ff.carry))
    else $error("and file to file destination wrong");

  bit_clear_a: assert property (
    exec && cmd_op == OP_BIT_CLEAR_FILE && cmd_file != PORT_ADDR
    |=> st_ff.file[$past(cmd_file)][$past(cmd_bit)] == 1'b0
        && $stable(st_ff.zero) && $stable(st_ff.carry))
    else $error("bit clear failed or flags moved");

  bit_set_a: assert property (
    exec && cmd_op == OP_BIT_SET_FILE && cmd_file != PORT_ADDR
    |=> st_ff.file[$past(cmd_file)][$past(cmd_bit)] == 1'b1
        && $stable(st_ff.half_carry))
    else $error("bit set failed or flags moved");

  skip_zero_a: assert property (
    exec && cmd_op == OP_TEST_BIT_SKIP_ZERO |=> st_ff.skip == !$past(test_bit))
    else $error("skip if zero decision wrong");

  skip_one_a: assert property (
    exec && cmd_op == OP_TEST_BIT_SKIP_ONE |=> st_ff.skip == $past(test_bit))
    else $error("skip if one decision wrong");

  skip_discard_a: assert property (
    drop |=> !st_ff.skip && $stable(st_ff.acc) && $stable(st_ff.file))
    else $error("discarded command had an effect");

  test_flags_a: assert property (
    exec && cmd_op inside {OP_TEST_BIT_SKIP_ZERO, OP_TEST_BIT_SKIP_ONE}
    |=> $stable(st_ff.zero) && $stable(st_ff.carry) && $stable(st_ff.acc))
    else $error("bit test modified state");

  pin_operand_a: assert property (
    exec && cmd_op == OP_AND_ACC_WITH_FILE && cmd_file == PORT_ADDR && !cmd_dest
    |=> st_ff.acc == ($past(st_ff.acc) & $past(st_ff.pin_s2)))
    else $error("port operand not taken from pins");

  presc_clear_a: assert property (
    exec && cmd_op inside {OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE}
    && cmd_file == TIMER_ZERO_ADDR |=> PRESCALER_CLR == $past(st_ff.psa) ##1 !PRESCALER_CLR)
    else $error("prescaler clear wrong");

  zero_flag_a: assert property (
    exec && cmd_op inside {OP_ADD_LITERAL_TO_ACC, OP_AND_LITERAL_WITH_ACC}
    |=> st_ff.zero == (st_ff.acc == 8'h00))
    else $error("zero flag disagrees with result");

  carry_flags_a: assert property (
    exec && cmd_op == OP_ADD_LITERAL_TO_ACC
    |=> st_ff.carry == ((9'($past(st_ff.acc)) + 9'($past(cmd_lit))) > 9'h0FF)
        && st_ff.half_carry == ((5'($past(st_ff.acc[3:0])) + 5'($past(cmd_lit[3:0])))
        > 5'h0F))
    else $error("carry or half carry wrong");

  add_file_cv: cover property (exec && cmd_op == OP_ADD_ACC_AND_FILE && cmd_dest);
  skip_taken_cv: cover property (exec && cmd_op == OP_TEST_BIT_SKIP_ONE && test_bit);
  discard_cv: cover property (drop);
  presc_cv: cover property (PRESCALER_CLR);

endmodule : adbo_datapath

/* dv/adbo_datapath_tb.sv */
// self-checking bench for the add and bit operations datapath
`timescale 1ns/10ps

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("MISMATCH at %0t got %h exp %h", $time, (g), (e)); \
    end \
  end

module adbo_datapath_tb
  import adbo_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  port_pins;
  logic [7:0]  port_latch;
  logic        prescaler_clr;
  logic [31:0] rd;
  logic [7:0]  t_acc [4];
  logic [7:0]  t_lit [4];
  logic [7:0]  t_res [4];
  logic [7:0]  t_st  [4];
  int          mismatches;
  int          checks_done;

  ////////////////////////////////////////////////////////////////////////////
  // device under test
  adbo_datapath uut (
    .CLK             (clk),
    .SYS_RST         (sys_rst),
    .AVS_ADDRESS     (avs_address),
    .AVS_READ        (avs_read),
    .AVS_WRITE       (avs_write),
    .AVS_WRITEDATA   (avs_writedata),
    .AVS_READDATA    (avs_readdata),
    .AVS_WAITREQUEST (avs_waitrequest),
    .PORT_PINS       (port_pins),
    .PORT_LATCH      (port_latch),
    .PRESCALER_CLR   (prescaler_clr)
  );

  // free running 100 MHz clock
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // wait for waitrequest low, take read data, end on that edge
  // sampled at each rising edge; a hang is ended by the watchdog only
  task automatic wait_ack;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    rd = avs_readdata;
  endtask : wait_ack

  // one avalon write, request raised right after an edge
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_ack();
    avs_write     <= 1'b0;
  endtask : bus_wr

  // one avalon read compared with an 8-bit expectation
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    avs_read    <= 1'b0;
    `CHK(rd, {24'h000000, e})
  endtask : rd_chk

  // command word: literal, file, dest, bit, op
  task automatic exec(input adbo_op_t op, input logic [7:0] k, input logic [6:0] f,
                      input logic d, input logic [2:0] b);
    bus_wr(REG_CMD, {9'h000, op, 1'b0, b, d, f, k});
  endtask : exec

  task automatic file_wr(input logic [6:0] f, input logic [7:0] v);
    bus_wr(REG_FADDR, {25'h0000000, f});
    bus_wr(REG_FDATA, {24'h000000, v});
  endtask : file_wr

  task automatic file_chk(input logic [6:0] f, input logic [7:0] e);
    bus_wr(REG_FADDR, {25'h0000000, f});
    rd_chk(REG_FDATA, e);
  endtask : file_chk

  // pulse is looked at in the cycle after the commit edge
  task automatic pulse_chk(input logic e);
    @(negedge clk);
    `CHK(prescaler_clr, e)
  endtask : pulse_chk

  task automatic print_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    port_pins = 8'h3C;
    mismatches = 0;
    checks_done = 0;
    t_acc = '{8'h0F, 8'h10, 8'h01, 8'h3C};
    t_lit = '{8'h01, 8'hF0, 8'hFF, 8'h41};
    t_res = '{8'h10, 8'h00, 8'h00, 8'h7D};
    t_st  = '{8'h02, 8'h05, 8'h07, 8'h00};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, unmapped and write-only reads
    rd_chk(REG_ACC, ACC_RST);
    rd_chk(REG_STATUS, 8'h00);
    rd_chk(REG_CTRL, 8'h00);
    rd_chk(REG_FADDR, 8'h00);
    rd_chk(REG_CMD, 8'h00);
    rd_chk(5'h18, 8'h00);
    // add literal: half carry, carry, zero, boundary 255
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(REG_ACC, {24'h000000, t_acc[i]});
      exec(OP_ADD_LITERAL_TO_ACC, t_lit[i], 7'h00, 1'b0, 3'h0);
      rd_chk(REG_ACC, t_res[i]);
      rd_chk(REG_STATUS, t_st[i]);
    end
    // add file, both destinations, top address
    file_wr(7'h7F, 8'h88);
    bus_wr(REG_ACC, 32'h00000088);
    exec(OP_ADD_ACC_AND_FILE, 8'h00, 7'h7F, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h10);
    rd_chk(REG_STATUS, 8'h03);
    file_chk(7'h7F, 8'h88);
    exec(OP_ADD_ACC_AND_FILE, 8'h00, 7'h7F, 1'b1, 3'h0);
    file_chk(7'h7F, 8'h98);
    rd_chk(REG_ACC, 8'h10);
    rd_chk(REG_STATUS, 8'h00);
    // and literal keeps carry and half carry
    bus_wr(REG_STATUS, 32'h00000003);
    bus_wr(REG_ACC, 32'h000000F0);
    exec(OP_AND_LITERAL_WITH_ACC, 8'h0F, 7'h00, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h00);
    rd_chk(REG_STATUS, 8'h07);
    bus_wr(REG_ACC, 32'h0000003C);
    exec(OP_AND_LITERAL_WITH_ACC, 8'hF0, 7'h00, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h30);
    rd_chk(REG_STATUS, 8'h03);
    // and file into the file register
    bus_wr(REG_STATUS, 32'h00000000);
    file_wr(7'h20, 8'hA5);
    bus_wr(REG_ACC, 32'h0000005A);
    exec(OP_AND_ACC_WITH_FILE, 8'h00, 7'h20, 1'b1, 3'h0);
    file_chk(7'h20, 8'h00);
    rd_chk(REG_ACC, 8'h5A);
    rd_chk(REG_STATUS, 8'h04);
    // bit clear and set on every position, flags held
    bus_wr(REG_STATUS, 32'h00000007);
    for (int b = 0; b < 8; b++)
    begin
      file_wr(7'h30, 8'hFF);
      exec(OP_BIT_CLEAR_FILE, 8'h00, 7'h30, 1'b0, b[2:0]);
      file_chk(7'h30, 8'hFF & ~(8'h01 << b));
      file_wr(7'h31, 8'h00);
      exec(OP_BIT_SET_FILE, 8'h00, 7'h31, 1'b0, b[2:0]);
      file_chk(7'h31, 8'h01 << b);
    end
    rd_chk(REG_STATUS, 8'h07);
    // bit tests: false keeps next command, true discards it
    bus_wr(REG_STATUS, 32'h00000005);
    bus_wr(REG_ACC, 32'h00000010);
    file_wr(7'h32, 8'h10);
    exec(OP_TEST_BIT_SKIP_ZERO, 8'h00, 7'h32, 1'b0, 3'h4);
    rd_chk(REG_STATUS, 8'h05);
    exec(OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h00, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h11);
    bus_wr(REG_STATUS, 32'h00000005);
    exec(OP_TEST_BIT_SKIP_ZERO, 8'h00, 7'h32, 1'b0, 3'h0);
    rd_chk(REG_STATUS, 8'h0D);
    exec(OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h00, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h11);
    rd_chk(REG_STATUS, 8'h05);
    exec(OP_TEST_BIT_SKIP_ONE, 8'h00, 7'h32, 1'b0, 3'h0);
    exec(OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h00, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h12);
    bus_wr(REG_STATUS, 32'h00000005);
    exec(OP_TEST_BIT_SKIP_ONE, 8'h00, 7'h32, 1'b0, 3'h4);
    rd_chk(REG_STATUS, 8'h0D);
    exec(OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h00, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h12);
    file_chk(7'h32, 8'h10);
    // port read-modify-write takes the pins, not the latch
    file_wr(7'h05, 8'hC3);
    exec(OP_BIT_SET_FILE, 8'h00, 7'h05, 1'b0, 3'h0);
    @(negedge clk);
    `CHK(port_latch, 8'h3D)
    // and with the port into the accumulator reads pins, not the latch
    bus_wr(REG_ACC, 32'h000000FF);
    exec(OP_AND_ACC_WITH_FILE, 8'h00, 7'h05, 1'b0, 3'h0);
    rd_chk(REG_ACC, 8'h3C);
    `CHK(port_latch, 8'h3D)
    // timer zero writes clear the prescaler only when assigned
    bus_wr(REG_CTRL, 32'h00000001);
    rd_chk(REG_CTRL, 8'h01);
    exec(OP_BIT_SET_FILE, 8'h00, 7'h01, 1'b0, 3'h2);
    pulse_chk(1'b1);
    exec(OP_ADD_ACC_AND_FILE, 8'h00, 7'h01, 1'b1, 3'h0);
    pulse_chk(1'b1);
    exec(OP_ADD_ACC_AND_FILE, 8'h00, 7'h01, 1'b0, 3'h0);
    pulse_chk(1'b0);
    file_wr(7'h01, 8'h55);
    pulse_chk(1'b0);
    bus_wr(REG_CTRL, 32'h00000000);
    exec(OP_BIT_CLEAR_FILE, 8'h00, 7'h01, 1'b0, 3'h2);
    pulse_chk(1'b0);
    print_verdict();
  end

endmodule : adbo_datapath_tb
